// ### rtl/lmq_pkg.sv
`default_nettype none
package lmq_pkg;
	// register offsets, byte addresses
	localparam logic [11:0] OFS_IDENT = 12'h000;
	localparam logic [11:0] OFS_VERSION = 12'h004;
	localparam logic [11:0] OFS_DEVICE_CODE = 12'h008;
	localparam logic [11:0] OFS_MAKER_CODE = 12'h00C;
	localparam logic [11:0] OFS_OFFERED = 12'h010;
	localparam logic [11:0] OFS_OFFERED_SEL = 12'h014;
	localparam logic [11:0] OFS_ACCEPTED = 12'h020;
	localparam logic [11:0] OFS_ACCEPTED_SEL = 12'h024;
	localparam logic [11:0] OFS_PAGE_BYTES = 12'h028;
	localparam logic [11:0] OFS_RING_SELECT = 12'h030;
	localparam logic [11:0] OFS_RING_CAPACITY = 12'h034;
	localparam logic [11:0] OFS_RING_COUNT = 12'h038;
	localparam logic [11:0] OFS_RING_ALIGN = 12'h03C;
	localparam logic [11:0] OFS_RING_PFN = 12'h040;
	localparam logic [11:0] OFS_DOORBELL = 12'h050;
	localparam logic [11:0] OFS_PENDING = 12'h060;
	localparam logic [11:0] OFS_EVENT_ACK = 12'h064;
	localparam logic [11:0] OFS_PROGRESS = 12'h070;
	localparam logic [11:0] OFS_SETTINGS = 12'h100;

	// fixed answer of the version register: page-based layout
	localparam logic [31:0] LEGACY_VERSION = 32'h0000_0001;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;

	// event bits of the pending flags register
	localparam int EVT_USED_BIT = 0;
	localparam int EVT_CONFIG_BIT = 1;
	localparam int EVT_BITS = 2;

	// ring layout: descriptor entry, avail header+tail, avail entry
	localparam logic [63:0] DESC_ENTRY_BYTES = 64'h0000_0000_0000_0010;
	localparam logic [63:0] AVAIL_FIXED_BYTES = 64'h0000_0000_0000_0006;
	localparam logic [63:0] AVAIL_ENTRY_BYTES = 64'h0000_0000_0000_0002;

	// defaults of the top parameters
	localparam int NUM_RINGS_DEF = 8;
	localparam int RING_CAPACITY_DEF = 256;
	localparam int FEATURE_WORDS_DEF = 2;
	localparam int SETTINGS_BYTES_DEF = 16;

	typedef enum logic [1:0] {
		LMQ_IDLE = 2'b01,
		LMQ_EXEC = 2'b10
	} lmq_fsm_t;
endpackage
`default_nettype wire

// ### rtl/lmq_ring_store.sv
`timescale 1ns/10ps
`default_nettype none
module lmq_ring_store #(
	parameter int NUM_RINGS = 8,
	parameter int IDX_W = 3
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clear_pfn,
	input wire logic wr_count,
	input wire logic wr_align,
	input wire logic wr_pfn,
	input wire logic [IDX_W-1:0] wr_index,
	input wire logic [31:0] wr_data,
	input wire logic [IDX_W-1:0] rd_index,
	output logic [31:0] rd_count,
	output logic [31:0] rd_align,
	output logic [31:0] rd_pfn
);
	typedef struct packed {
		logic [NUM_RINGS-1:0][31:0] count;
		logic [NUM_RINGS-1:0][31:0] align;
		logic [NUM_RINGS-1:0][31:0] pfn;
		logic [31:0] rc;
		logic [31:0] ra;
		logic [31:0] rp;
	} lmq_store_t;

	lmq_store_t st;
	lmq_store_t next_st;

	// per-ring write, then registered read of the indexed ring
	always_comb begin
		next_st = st;
		for (int i = 0; i < NUM_RINGS; i++) begin
			if (wr_count && wr_index == IDX_W'(i)) begin
				next_st.count[i] = wr_data;
			end
			if (wr_align && wr_index == IDX_W'(i)) begin
				next_st.align[i] = wr_data;
			end
			if (wr_pfn && wr_index == IDX_W'(i)) begin
				next_st.pfn[i] = wr_data;
			end
			if (clear_pfn) begin
				next_st.pfn[i] = 32'h0000_0000;
			end
		end
		next_st.rc = st.count[rd_index];
		next_st.ra = st.align[rd_index];
		next_st.rp = st.pfn[rd_index];
	end

	// all storage zero at reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rd_count = st.rc;
	assign rd_align = st.ra;
	assign rd_pfn = st.rp;
endmodule // lmq_ring_store
`default_nettype wire

// ### rtl/lmq_register_bank.sv
// What this block does
// - version register always reads the fixed legacy layout code.
// - ring base address is page frame times page size.
// - ring select write picks the ring for later ring accesses.
// - capacity read gives the ring maximum, or zero if absent.
// - element count write is stored for the selected ring.
// - used-ring alignment, power of two, stored for the selected ring.
// - page frame write is stored for the selected ring.
// - page frame read gives the selected ring's page; nonzero is busy.
// - progress read gives flags; nonzero write sets reported flags.
// - zero written to progress resets and clears every page frame.
// - used ring is placed on the stored alignment boundary.
// - offered feature word follows the last offered word select.
// - accepted feature bits are stored in the selected word.
// - settings space starts at 0x100 with byte accesses.
// - doorbell write tells that a ring has new buffers.
// - event bits stay set until acknowledged by mask or cleared by a zero progress write.
// - interrupt output is high while any event bit is set.
`timescale 1ns/10ps
`default_nettype none
module lmq_register_bank #(
	parameter int NUM_RINGS = lmq_pkg::NUM_RINGS_DEF,
	parameter int RING_CAPACITY = lmq_pkg::RING_CAPACITY_DEF,
	parameter int FEATURE_WORDS = lmq_pkg::FEATURE_WORDS_DEF,
	parameter int SETTINGS_BYTES = lmq_pkg::SETTINGS_BYTES_DEF,
	// arbitrary value
	parameter logic [31:0] IDENT_SIGNATURE = 32'h5A5A_0F0F,
	// arbitrary value
	parameter logic [31:0] DEVICE_CODE = 32'h0000_0042,
	// arbitrary value
	parameter logic [31:0] MAKER_CODE = 32'h0000_ABCD,
	parameter logic [FEATURE_WORDS*32-1:0] OFFERED_FEATURES = '0
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic acc_req,
	input wire logic acc_write,
	input wire logic [11:0] acc_addr,
	input wire logic [31:0] acc_wdata,
	output logic acc_busy,
	output logic acc_ack,
	output logic [31:0] acc_rdata,
	input wire logic evt_used_buffer,
	input wire logic evt_config_change,
	output logic irq,
	output logic doorbell_pulse,
	output logic [31:0] doorbell_ring,
	output logic device_reset_pulse,
	output logic [31:0] progress_flags,
	output logic [63:0] ring_base_addr,
	output logic [63:0] ring_used_addr,
	output logic [31:0] ring_elements
);
	localparam int IDX_W = (NUM_RINGS > 1) ? $clog2(NUM_RINGS) : 1;
	localparam int FSEL_W = (FEATURE_WORDS > 1) ? $clog2(FEATURE_WORDS) : 1;
	localparam int CFG_W = (SETTINGS_BYTES > 1) ? $clog2(SETTINGS_BYTES) : 1;

	// refuse sizes the decode cannot serve
	if (NUM_RINGS < 1 || NUM_RINGS > 256) begin : g_chk_rings
		$error("lmq_register_bank: NUM_RINGS out of range");
	end
	if (FEATURE_WORDS < 1) begin : g_chk_feat
		$error("lmq_register_bank: FEATURE_WORDS out of range");
	end
	if (SETTINGS_BYTES < 1 || SETTINGS_BYTES > 3840) begin : g_chk_cfg
		$error("lmq_register_bank: SETTINGS_BYTES out of range");
	end
	if (RING_CAPACITY < 1 || RING_CAPACITY > 32768) begin : g_chk_cap
		$error("lmq_register_bank: RING_CAPACITY out of range");
	end

	typedef struct packed {
		lmq_pkg::lmq_fsm_t fsm;
		logic op_write;
		logic [11:0] op_addr;
		logic [31:0] op_wdata;
		logic [31:0] ring_sel;
		logic [31:0] page_bytes;
		logic [31:0] offered_sel;
		logic [31:0] accepted_sel;
		logic [FEATURE_WORDS-1:0][31:0] accepted;
		logic [31:0] progress;
		logic [lmq_pkg::EVT_BITS-1:0] pending;
		logic [SETTINGS_BYTES-1:0][7:0] settings;
		logic busy;
		logic ack;
		logic [31:0] rdata;
		logic irq;
		logic doorbell;
		logic [31:0] doorbell_ring;
		logic dev_reset;
		logic [63:0] base_addr;
		logic [63:0] used_addr;
		logic [31:0] elements;
	} lmq_state_t;

	lmq_state_t st;
	lmq_state_t next_st;
	logic [1:0] rst_sync;
	logic rst_n;

	// release of the asynchronous reset through two flops
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// does an operation hit the settings window
	function automatic logic settings_hit(input logic [11:0] a);
		settings_hit = (a >= lmq_pkg::OFS_SETTINGS) &&
			(32'(a) < 32'(lmq_pkg::OFS_SETTINGS) + SETTINGS_BYTES);
	endfunction

	// is the selected ring one that exists
	function automatic logic ring_exists(input logic [31:0] sel);
		ring_exists = sel < NUM_RINGS;
	endfunction

	logic sel_ok;
	logic exec_write;
	logic wr_count;
	logic wr_align;
	logic wr_pfn;
	logic clear_pfn;
	logic [31:0] q_count;
	logic [31:0] q_align;
	logic [31:0] q_pfn;
	logic [CFG_W-1:0] cfg_idx;
	logic [63:0] used_raw;
	logic [63:0] align_mask;

	assign sel_ok = ring_exists(st.ring_sel);
	assign exec_write = (st.fsm == lmq_pkg::LMQ_EXEC) && st.op_write;
	assign cfg_idx = CFG_W'(st.op_addr - lmq_pkg::OFS_SETTINGS);

	// ring storage strobes; a missing ring takes no writes
	assign wr_count = exec_write && sel_ok &&
		st.op_addr == lmq_pkg::OFS_RING_COUNT;
	assign wr_align = exec_write && sel_ok &&
		st.op_addr == lmq_pkg::OFS_RING_ALIGN;
	assign wr_pfn = exec_write && sel_ok &&
		st.op_addr == lmq_pkg::OFS_RING_PFN;
	assign clear_pfn = exec_write && st.op_wdata == lmq_pkg::WORD_RESET &&
		st.op_addr == lmq_pkg::OFS_PROGRESS;

	lmq_ring_store #(
		.NUM_RINGS(NUM_RINGS),
		.IDX_W(IDX_W)
	) u_store (
		.clock(clock),
		.rst_n(rst_n),
		.clear_pfn(clear_pfn),
		.wr_count(wr_count),
		.wr_align(wr_align),
		.wr_pfn(wr_pfn),
		.wr_index(IDX_W'(st.ring_sel)),
		.wr_data(st.op_wdata),
		.rd_index(IDX_W'(st.ring_sel)),
		.rd_count(q_count),
		.rd_align(q_align),
		.rd_pfn(q_pfn)
	);

	// used ring follows descriptors and avail ring, rounded up
	assign used_raw = st.base_addr +
		64'(q_count) * lmq_pkg::DESC_ENTRY_BYTES +
		64'(q_count) * lmq_pkg::AVAIL_ENTRY_BYTES + lmq_pkg::AVAIL_FIXED_BYTES;
	assign align_mask = (q_align == 32'h0000_0000) ? 64'h0 :
		64'(q_align) - 64'h1;

	// one operation at a time: take, then execute and answer
	always_comb begin
		next_st = st;
		next_st.ack = 1'b0;
		next_st.doorbell = 1'b0;
		next_st.dev_reset = 1'b0;
		// events win over an acknowledge in the same cycle
		next_st.pending[lmq_pkg::EVT_USED_BIT] =
			st.pending[lmq_pkg::EVT_USED_BIT] | evt_used_buffer;
		next_st.pending[lmq_pkg::EVT_CONFIG_BIT] =
			st.pending[lmq_pkg::EVT_CONFIG_BIT] | evt_config_change;
		// addresses of the selected ring, refreshed every cycle
		next_st.base_addr = 64'(q_pfn) * 64'(st.page_bytes);
		next_st.used_addr = (used_raw + align_mask) & ~align_mask;
		next_st.elements = q_count;
		case (st.fsm)
			lmq_pkg::LMQ_IDLE: begin
				if (acc_req) begin
					next_st.fsm = lmq_pkg::LMQ_EXEC;
					next_st.busy = 1'b1;
					next_st.op_write = acc_write;
					next_st.op_addr = acc_addr;
					next_st.op_wdata = acc_wdata;
				end
			end
			lmq_pkg::LMQ_EXEC: begin
				next_st.fsm = lmq_pkg::LMQ_IDLE;
				next_st.busy = 1'b0;
				next_st.ack = 1'b1;
				next_st.rdata = 32'h0000_0000;
				if (st.op_write) begin
					// read-only and unknown offsets ignore writes
					case (st.op_addr)
						lmq_pkg::OFS_OFFERED_SEL: begin
							next_st.offered_sel = st.op_wdata;
						end
						lmq_pkg::OFS_ACCEPTED: begin
							if (st.accepted_sel < FEATURE_WORDS) begin
								next_st.accepted[FSEL_W'(st.accepted_sel)] =
									st.op_wdata;
							end
						end
						lmq_pkg::OFS_ACCEPTED_SEL: begin
							next_st.accepted_sel = st.op_wdata;
						end
						lmq_pkg::OFS_PAGE_BYTES: begin
							next_st.page_bytes = st.op_wdata;
						end
						lmq_pkg::OFS_RING_SELECT: begin
							next_st.ring_sel = st.op_wdata;
						end
						lmq_pkg::OFS_DOORBELL: begin
							next_st.doorbell = 1'b1;
							next_st.doorbell_ring = st.op_wdata;
						end
						lmq_pkg::OFS_EVENT_ACK: begin
							next_st.pending = (st.pending &
								~st.op_wdata[lmq_pkg::EVT_BITS-1:0]) |
								{evt_config_change, evt_used_buffer};
						end
						lmq_pkg::OFS_PROGRESS: begin
							if (st.op_wdata == lmq_pkg::WORD_RESET) begin
								// soft reset; a same-cycle event still lands
								next_st.progress = lmq_pkg::WORD_RESET;
								next_st.pending =
									{evt_config_change, evt_used_buffer};
								next_st.dev_reset = 1'b1;
							end else begin
								next_st.progress = st.progress |
									st.op_wdata;
							end
						end
						default: begin
							if (settings_hit(st.op_addr)) begin
								next_st.settings[cfg_idx] =
									st.op_wdata[7:0];
							end
						end
					endcase
				end else begin
					// write-only offsets fall to the zero default
					case (st.op_addr)
						lmq_pkg::OFS_IDENT: next_st.rdata = IDENT_SIGNATURE;
						lmq_pkg::OFS_VERSION: begin
							next_st.rdata = lmq_pkg::LEGACY_VERSION;
						end
						lmq_pkg::OFS_DEVICE_CODE: next_st.rdata = DEVICE_CODE;
						lmq_pkg::OFS_MAKER_CODE: next_st.rdata = MAKER_CODE;
						lmq_pkg::OFS_OFFERED: begin
							if (st.offered_sel < FEATURE_WORDS) begin
								next_st.rdata = OFFERED_FEATURES[
									32*FSEL_W'(st.offered_sel) +: 32];
							end
						end
						lmq_pkg::OFS_RING_CAPACITY: begin
							if (sel_ok) begin
								next_st.rdata = 32'(RING_CAPACITY);
							end
						end
						lmq_pkg::OFS_RING_PFN: begin
							if (sel_ok) begin
								next_st.rdata = q_pfn;
							end
						end
						lmq_pkg::OFS_PENDING: begin
							next_st.rdata = 32'(st.pending);
						end
						lmq_pkg::OFS_PROGRESS: begin
							next_st.rdata = st.progress;
						end
						default: begin
							if (settings_hit(st.op_addr)) begin
								next_st.rdata = {24'h000000,
									st.settings[cfg_idx]};
							end
						end
					endcase
				end
			end
			default: begin
				next_st.fsm = lmq_pkg::LMQ_IDLE;
				next_st.busy = 1'b0;
			end
		endcase
		next_st.irq = |next_st.pending;
	end

	// single state register of the bank
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.fsm <= lmq_pkg::LMQ_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// every output straight from the state flops
	assign acc_busy = st.busy;
	assign acc_ack = st.ack;
	assign acc_rdata = st.rdata;
	assign irq = st.irq;
	assign doorbell_pulse = st.doorbell;
	assign doorbell_ring = st.doorbell_ring;
	assign device_reset_pulse = st.dev_reset;
	assign progress_flags = st.progress;
	assign ring_base_addr = st.base_addr;
	assign ring_used_addr = st.used_addr;
	assign ring_elements = st.elements;
endmodule // lmq_register_bank
`default_nettype wire

// ### testbench/lmq_bank_checker.sv
`timescale 1ns/10ps
`default_nettype none
module lmq_bank_checker (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic acc_req,
	input wire logic acc_write,
	input wire logic [11:0] acc_addr,
	input wire logic [31:0] acc_wdata,
	input wire logic acc_busy,
	input wire logic acc_ack,
	input wire logic [31:0] acc_rdata,
	input wire logic evt_used_buffer,
	input wire logic irq,
	input wire logic doorbell_pulse,
	input wire logic [31:0] doorbell_ring,
	input wire logic device_reset_pulse,
	input wire logic [31:0] progress_flags
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);

	// a request is taken only while the port is idle
	sequence s_take;
		acc_req && !acc_busy;
	endsequence
	sequence s_rd(logic [11:0] a);
		s_take ##0 (!acc_write && acc_addr == a);
	endsequence
	sequence s_wr(logic [11:0] a);
		s_take ##0 (acc_write && acc_addr == a);
	endsequence

	property p_answer;
		s_take |=> acc_busy ##1 (acc_ack && !acc_busy);
	endproperty
	a_answer: assert property (p_answer)
		else $error("access not answered two cycles after take");
	property p_version;
		s_rd(lmq_pkg::OFS_VERSION) |->
			##2 acc_rdata == lmq_pkg::LEGACY_VERSION;
	endproperty
	a_version: assert property (p_version)
		else $error("version read gave wrong code");
	property p_wo_zero;
		s_rd(lmq_pkg::OFS_RING_SELECT) |-> ##2 acc_rdata == 32'h0000_0000;
	endproperty
	a_wo_zero: assert property (p_wo_zero)
		else $error("write-only register read not zero");
	property p_doorbell;
		s_wr(lmq_pkg::OFS_DOORBELL) |-> ##2
			(doorbell_pulse && doorbell_ring == $past(acc_wdata, 2));
	endproperty
	a_doorbell: assert property (p_doorbell)
		else $error("doorbell write not signalled");
	property p_db_pulse;
		doorbell_pulse |-> acc_ack ##1 !doorbell_pulse;
	endproperty
	a_db_pulse: assert property (p_db_pulse)
		else $error("doorbell pulse without answer or too long");
	property p_soft_reset;
		s_wr(lmq_pkg::OFS_PROGRESS) ##0 acc_wdata == 32'h0000_0000 |-> ##2
			(device_reset_pulse && progress_flags == 32'h0000_0000);
	endproperty
	a_soft_reset: assert property (p_soft_reset)
		else $error("zero progress write did not reset");
	property p_reset_pulse;
		device_reset_pulse |-> acc_ack ##1 !device_reset_pulse;
	endproperty
	a_reset_pulse: assert property (p_reset_pulse)
		else $error("reset pulse without answer or too long");
	property p_progress;
		s_wr(lmq_pkg::OFS_PROGRESS) ##0 acc_wdata != 32'h0000_0000 |-> ##2
			progress_flags == ($past(progress_flags, 2) | $past(acc_wdata, 2));
	endproperty
	a_progress: assert property (p_progress)
		else $error("progress flags not set by write");
	property p_irq_set;
		evt_used_buffer |-> ##2 irq;
	endproperty
	a_irq_set: assert property (p_irq_set)
		else $error("event did not raise interrupt");
	// flag and irq clear together at an answer edge, so ack is high then
	property p_irq_hold;
		$fell(irq) |-> acc_ack;
	endproperty
	a_irq_hold: assert property (p_irq_hold)
		else $error("interrupt dropped without acknowledge");
endmodule // lmq_bank_checker
`default_nettype wire

// ### testbench/lmq_register_bank_bench.sv
`timescale 1ns/10ps
`default_nettype none
module lmq_register_bank_bench;
	localparam logic [31:0] ID_SIG = 32'h600D_CAFE; // arbitrary value
	localparam logic [31:0] DEV_CODE = 32'h0000_0077; // arbitrary value
	localparam logic [31:0] MK_CODE = 32'h0000_1357; // arbitrary value
	localparam logic [63:0] FEAT = 64'h0000_0003_8000_0021;
	logic clock = 1'b0;
	logic arst_n, acc_req, acc_write, acc_busy, acc_ack;
	logic [11:0] acc_addr;
	logic [31:0] acc_wdata, acc_rdata, doorbell_ring, progress_flags;
	logic [31:0] ring_elements;
	logic evt_used_buffer, evt_config_change, irq;
	logic doorbell_pulse, device_reset_pulse, db_seen, rst_seen;
	logic [63:0] ring_base_addr, ring_used_addr;
	int errors = 0;
	int total_checks = 0;

	lmq_register_bank #(.IDENT_SIGNATURE(ID_SIG), .DEVICE_CODE(DEV_CODE),
		.MAKER_CODE(MK_CODE), .OFFERED_FEATURES(FEAT)) uut (
		.clock(clock), .arst_n(arst_n), .acc_req(acc_req),
		.acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
		.acc_busy(acc_busy), .acc_ack(acc_ack), .acc_rdata(acc_rdata),
		.evt_used_buffer(evt_used_buffer),
		.evt_config_change(evt_config_change), .irq(irq),
		.doorbell_pulse(doorbell_pulse), .doorbell_ring(doorbell_ring),
		.device_reset_pulse(device_reset_pulse),
		.progress_flags(progress_flags), .ring_base_addr(ring_base_addr),
		.ring_used_addr(ring_used_addr), .ring_elements(ring_elements));

	always #5 clock = ~clock;

	task automatic give_verdict();
		$display("checks=%0d errors=%0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// request held until the answer edge, released on the next falling edge
	task automatic acc(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		@(negedge clock);
		acc_req = 1'b1;
		acc_write = w;
		acc_addr = a;
		acc_wdata = d;
		n = 0;
		do begin
			@(posedge clock);
			#1;
			n++;
		end while (acc_ack !== 1'b1 && n < 8);
		if (n == 8) check(1'b0, 1'b1);
		q = acc_rdata;
		db_seen = doorbell_pulse;
		rst_seen = device_reset_pulse;
		@(negedge clock);
		acc_req = 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		acc(1'b1, a, d, q);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		acc(1'b0, a, 32'h0000_0000, q);
		check(q, exp);
	endtask

	task automatic t_ident();
		rdc(lmq_pkg::OFS_IDENT, ID_SIG);
		rdc(lmq_pkg::OFS_VERSION, lmq_pkg::LEGACY_VERSION);
		rdc(lmq_pkg::OFS_DEVICE_CODE, DEV_CODE);
		rdc(lmq_pkg::OFS_MAKER_CODE, MK_CODE);
		wr(lmq_pkg::OFS_VERSION, 32'hFFFF_FFFF);
		rdc(lmq_pkg::OFS_VERSION, lmq_pkg::LEGACY_VERSION);
		rdc(12'h006, 32'h0000_0000);
		rdc(12'h0F0, 32'h0000_0000);
		rdc(lmq_pkg::OFS_RING_SELECT, 32'h0000_0000);
	endtask

	task automatic t_features();
		wr(lmq_pkg::OFS_OFFERED_SEL, 32'h0000_0001);
		rdc(lmq_pkg::OFS_OFFERED, FEAT[63:32]);
		wr(lmq_pkg::OFS_OFFERED_SEL, 32'h0000_0000);
		rdc(lmq_pkg::OFS_OFFERED, FEAT[31:0]);
		rdc(lmq_pkg::OFS_OFFERED_SEL, 32'h0000_0000);
		wr(lmq_pkg::OFS_ACCEPTED_SEL, 32'h0000_0001);
		wr(lmq_pkg::OFS_ACCEPTED, 32'h0000_0003);
		rdc(lmq_pkg::OFS_ACCEPTED, 32'h0000_0000);
		wr(lmq_pkg::OFS_SETTINGS, 32'h0000_00A5);
		rdc(lmq_pkg::OFS_SETTINGS, 32'h0000_00A5);
	endtask

	task automatic t_rings();
		wr(lmq_pkg::OFS_PAGE_BYTES, 32'h0000_1000);
		// ring 8 lies past the last ring and must read as absent
		for (int i = 0; i < 9; i++) begin
			wr(lmq_pkg::OFS_RING_SELECT, 32'(i));
			rdc(lmq_pkg::OFS_RING_PFN, 32'h0000_0000);
			rdc(lmq_pkg::OFS_RING_CAPACITY, (i < lmq_pkg::NUM_RINGS_DEF) ?
				32'(lmq_pkg::RING_CAPACITY_DEF) : 32'h0000_0000);
		end
		// element count below capacity, page frame never zero while in use
		wr(lmq_pkg::OFS_RING_SELECT, 32'h0000_0002);
		wr(lmq_pkg::OFS_RING_COUNT, 32'h0000_0010);
		wr(lmq_pkg::OFS_RING_ALIGN, 32'h0000_1000);
		wr(lmq_pkg::OFS_RING_PFN, 32'h0000_0020);
		rdc(lmq_pkg::OFS_RING_PFN, 32'h0000_0020);
		repeat (3) @(negedge clock);
		check(ring_base_addr, 64'h0000_0000_0002_0000);
		check(ring_elements, 32'h0000_0010);
		check(ring_used_addr, 64'h0000_0000_0002_1000);
		wr(lmq_pkg::OFS_RING_SELECT, 32'h0000_0003);
		rdc(lmq_pkg::OFS_RING_PFN, 32'h0000_0000);
		repeat (3) @(negedge clock);
		check(ring_elements, 32'h0000_0000);
		wr(lmq_pkg::OFS_RING_SELECT, 32'h0000_0008);
		wr(lmq_pkg::OFS_RING_PFN, 32'h0000_0033);
		rdc(lmq_pkg::OFS_RING_PFN, 32'h0000_0000);
		// a write to a missing ring must not alias onto ring 0
		wr(lmq_pkg::OFS_RING_SELECT, 32'h0000_0000);
		rdc(lmq_pkg::OFS_RING_PFN, 32'h0000_0000);
		wr(lmq_pkg::OFS_RING_SELECT, 32'h0000_0002);
		rdc(lmq_pkg::OFS_RING_PFN, 32'h0000_0020);
	endtask

	task automatic t_progress();
		wr(lmq_pkg::OFS_PROGRESS, 32'h0000_0001);
		check(rst_seen, 1'b0);
		wr(lmq_pkg::OFS_PROGRESS, 32'h0000_0004);
		rdc(lmq_pkg::OFS_PROGRESS, 32'h0000_0005);
		check(progress_flags, 32'h0000_0005);
		wr(lmq_pkg::OFS_PROGRESS, 32'h0000_0000);
		check(rst_seen, 1'b1);
		rdc(lmq_pkg::OFS_PROGRESS, 32'h0000_0000);
		rdc(lmq_pkg::OFS_RING_PFN, 32'h0000_0000);
		wr(lmq_pkg::OFS_DOORBELL, 32'h0000_0003);
		check(db_seen, 1'b1);
		check(doorbell_ring, 32'h0000_0003);
	endtask

	// one-cycle event pulse, then room for flag and irq to land
	task automatic ev(input logic u, input logic c);
		@(negedge clock);
		evt_used_buffer = u;
		evt_config_change = c;
		@(negedge clock);
		evt_used_buffer = 1'b0;
		evt_config_change = 1'b0;
		repeat (2) @(negedge clock);
	endtask

	task automatic t_events();
		check(irq, 1'b0);
		ev(1'b1, 1'b0);
		check(irq, 1'b1);
		rdc(lmq_pkg::OFS_PENDING, 32'h0000_0001);
		ev(1'b0, 1'b1);
		rdc(lmq_pkg::OFS_PENDING, 32'h0000_0003);
		wr(lmq_pkg::OFS_EVENT_ACK, 32'h0000_0001);
		rdc(lmq_pkg::OFS_PENDING, 32'h0000_0002);
		check(irq, 1'b1);
		wr(lmq_pkg::OFS_EVENT_ACK, 32'h0000_0002);
		repeat (2) @(negedge clock);
		check(irq, 1'b0);
		rdc(lmq_pkg::OFS_PENDING, 32'h0000_0000);
	endtask

	initial begin
		arst_n = 1'b0;
		acc_req = 1'b0;
		acc_write = 1'b0;
		acc_addr = 12'h000;
		acc_wdata = 32'h0000_0000;
		evt_used_buffer = 1'b0;
		evt_config_change = 1'b0;
		repeat (2) @(negedge clock);
		arst_n = 1'b1;
		repeat (4) @(negedge clock);
		t_ident();
		t_features();
		t_rings();
		t_progress();
		t_events();
		give_verdict();
	end

	// the whole sequence needs well under 1000 cycles
	initial begin
		#200000;
		errors++;
		give_verdict();
	end
endmodule // lmq_register_bank_bench

bind lmq_register_bank lmq_bank_checker u_chk (.clock(clock),
	.arst_n(arst_n), .acc_req(acc_req), .acc_write(acc_write),
	.acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_busy(acc_busy),
	.acc_ack(acc_ack), .acc_rdata(acc_rdata),
	.evt_used_buffer(evt_used_buffer), .irq(irq),
	.doorbell_pulse(doorbell_pulse), .doorbell_ring(doorbell_ring),
	.device_reset_pulse(device_reset_pulse),
	.progress_flags(progress_flags));
`default_nettype wire
